// [pwit_timer.sv]
// pwit_timer: password protected watchdog / interval timer with apb register access
// assumes ref_clk at 25 MHz, clock sources arriving as one-cycle tick enables, srst synchronous
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps

module pwit_timer (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// apb slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// counter clock sources, one-cycle enables, and fail levels for the sub-main clock and aclk
	input  wire logic        sub_main_clock_tick,
	input  wire logic        aclk_tick,
	input  wire logic        vlo_tick,
	input  wire logic        xclk_tick,
	input  wire logic        sub_main_clock_fail,
	input  wire logic        aclk_fail,
	// system side
	input  wire logic        other_soft_reset,
	input  wire logic        global_irq_enable,
	input  wire logic        irq_ack,
	output logic             soft_system_reset,
	output logic             interval_irq,
	output pwit_pkg::pwit_src_t clk_keep
);

	pwit_pkg::pwit_ctl_t ctl_q;
	logic [31:0]         timeout_counter_q;
	logic                timeout_flag_q;
	logic                interval_irq_enable_q;
	logic                pready_q;
	logic                pslverr_q;
	logic [31:0]         prdata_q;
	logic                wd_reset_q;
	logic                irq_q;
	pwit_pkg::pwit_src_t keep_q;

	logic        acc;
	logic        wr;
	logic        hit_ctl;
	logic        hit_byte;
	logic        hit_flag;
	logic        hit_ie;
	logic        full_word;
	logic        pw_bad;
	logic        byte_wr;
	logic        ctl_wr;
	logic        soft_rst;
	logic        failover;
	logic [1:0]  eff_src;
	logic        src_tick;
	logic        tick;
	logic [7:0]  tap_hit;
	logic        expire;
	logic        wd_reset;
	logic [7:0]  ctl_low;
	logic [31:0] rdata;

	// apb: one wait state so that read data can come from a flop
	assign acc       = psel & penable & ~pready_q;
	assign wr        = psel & penable & pready_q & pwrite;
	assign hit_ctl   = (paddr == pwit_pkg::ADDR_CTL);
	assign hit_byte  = (paddr == pwit_pkg::ADDR_BYTE);
	assign hit_flag  = (paddr == pwit_pkg::ADDR_FLAG);
	assign hit_ie    = (paddr == pwit_pkg::ADDR_IE);
	assign full_word = (pstrb[1:0] == 2'h3);

	assign pw_bad  = wr & hit_ctl & full_word & (pwdata[15:8] != pwit_pkg::PW_WRITE);
	assign byte_wr = wr & ((hit_ctl & ~full_word) | hit_byte);
	assign ctl_wr  = wr & hit_ctl & full_word & ~pw_bad;

	// own reset takes effect the cycle after it is raised
	assign soft_rst = wd_reset_q | other_soft_reset;

	// fail-safe only guards the watchdog; interval mode takes the source as chosen
	assign failover = ~ctl_q.tmsel &
		(((ctl_q.ssel == pwit_pkg::SRC_SUB_MAIN) & sub_main_clock_fail) |
		 ((ctl_q.ssel == pwit_pkg::SRC_ACLK) & aclk_fail));
	assign eff_src = failover ? pwit_pkg::SRC_VLO : ctl_q.ssel;

	always_comb begin
		unique case (eff_src)
			pwit_pkg::SRC_SUB_MAIN: src_tick = sub_main_clock_tick;
			pwit_pkg::SRC_ACLK:  src_tick = aclk_tick;
			pwit_pkg::SRC_VLO:   src_tick = vlo_tick;
			pwit_pkg::SRC_XCLK:  src_tick = xclk_tick;
		endcase
	end

	assign tick = src_tick & ~ctl_q.hold;

	// tap reached when all bits below the divider are ones
	for (genvar i = 0; i < 8; i++) begin : g_tap
		assign tap_hit[i] = &timeout_counter_q[pwit_pkg::TAP_W[i]-1:0];
	end

	assign expire = tick & tap_hit[ctl_q.isel];
	assign wd_reset = (~ctl_q.tmsel & expire) | pw_bad | byte_wr;

	// control register; counter clear is not stored
	always_ff @(posedge ref_clk) begin
		if (srst | soft_rst) begin
			ctl_q <= pwit_pkg::CTL_RST;
		end else if (ctl_wr) begin
			ctl_q.hold  <= pwdata[pwit_pkg::HOLD_BIT];
			ctl_q.ssel  <= pwdata[pwit_pkg::SSEL_LSB +: 2];
			ctl_q.tmsel <= pwdata[pwit_pkg::TMSEL_BIT];
			ctl_q.isel  <= pwdata[pwit_pkg::IS_LSB +: 3];
		end
	end

	// counter: reachable only through control writes; wraps freely in interval mode
	always_ff @(posedge ref_clk) begin
		if (srst | soft_rst) begin
			timeout_counter_q <= 32'h0;
		end else if (ctl_wr & pwdata[pwit_pkg::CLR_BIT]) begin
			timeout_counter_q <= 32'h0;
		end else if (tick) begin
			timeout_counter_q <= timeout_counter_q + 32'h1;
		end
	end

	// timeout flag: own reset set beats every clear except srst; other_soft_reset beats interval set, which beats ack and software clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			timeout_flag_q <= 1'b0;
		end else if (wd_reset_q) begin
			timeout_flag_q <= 1'b1;
		end else if (other_soft_reset) begin
			timeout_flag_q <= 1'b0;
		end else if (ctl_q.tmsel & expire) begin
			timeout_flag_q <= 1'b1;
		end else if (irq_ack & irq_q) begin
			timeout_flag_q <= 1'b0;
		end else if (wr & hit_flag & pstrb[0]) begin
			timeout_flag_q <= pwdata[pwit_pkg::FLAG_BIT];
		end
	end

	// interval enable: only software and reset touch it
	always_ff @(posedge ref_clk) begin
		if (srst | soft_rst) begin
			interval_irq_enable_q <= 1'b0;
		end else if (wr & hit_ie & pstrb[0]) begin
			interval_irq_enable_q <= pwdata[pwit_pkg::IE_BIT];
		end
	end

	// soft reset pulse and interval request leave on separate lines, hence separate vectors
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wd_reset_q <= 1'b0;
			irq_q      <= 1'b0;
		end else begin
			wd_reset_q <= wd_reset & ~wd_reset_q;
			irq_q <= ctl_q.tmsel & timeout_flag_q & interval_irq_enable_q & global_irq_enable;
		end
	end

	// keep-alive request to the clock system, watchdog mode only
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			keep_q <= '0;
		end else if (ctl_q.tmsel) begin
			keep_q <= '0;
		end else begin
			keep_q.sub_main_clock <= (eff_src == pwit_pkg::SRC_SUB_MAIN);
			keep_q.aclk  <= (eff_src == pwit_pkg::SRC_ACLK);
			keep_q.vlo   <= (eff_src == pwit_pkg::SRC_VLO);
			keep_q.xclk  <= (eff_src == pwit_pkg::SRC_XCLK);
		end
	end

	assign ctl_low = {ctl_q.hold, ctl_q.ssel, ctl_q.tmsel, 1'b0, ctl_q.isel};

	always_comb begin
		rdata = 32'h0;
		if (hit_ctl) begin
			rdata = {16'h0, pwit_pkg::PW_READ, ctl_low};
		end else if (hit_byte) begin
			rdata = {16'h0, ctl_low, ctl_low};
		end else if (hit_flag) begin
			rdata = {31'h0, timeout_flag_q};
		end else if (hit_ie) begin
			rdata = {31'h0, interval_irq_enable_q};
		end
	end

	// apb answer flops
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= acc;
			pslverr_q <= acc & ~(hit_ctl | hit_byte | hit_flag | hit_ie);
			prdata_q  <= (acc & ~pwrite) ? rdata : 32'h0;
		end
	end

	assign prdata            = prdata_q;
	assign pready            = pready_q;
	assign pslverr           = pslverr_q;
	assign soft_system_reset = wd_reset_q;
	assign interval_irq      = irq_q;
	assign clk_keep          = keep_q;

	property p_reset_default;
		@(posedge ref_clk) disable iff (srst)
		wd_reset_q |=> (ctl_q == pwit_pkg::CTL_RST) && (timeout_counter_q == 32'h0) && timeout_flag_q;
	endproperty
	a_reset_default: assert property (p_reset_default) else $error("soft reset did not restore defaults");

	property p_pw_bad;
		@(posedge ref_clk) disable iff (srst)
		(pw_bad && !wd_reset_q) |=> soft_system_reset;
	endproperty
	a_pw_bad: assert property (p_pw_bad) else $error("bad password did not reset");

	property p_read_pw;
		@(posedge ref_clk) disable iff (srst)
		(pready && psel && !pwrite && hit_ctl && !pslverr) |-> (prdata[15:8] == pwit_pkg::PW_READ);
	endproperty
	a_read_pw: assert property (p_read_pw) else $error("control read upper byte wrong");

	property p_byte_read;
		@(posedge ref_clk) disable iff (srst)
		(pready && psel && !pwrite && hit_byte) |-> (prdata[15:8] == prdata[7:0]) && (prdata[7:0] == $past(ctl_low));
	endproperty
	a_byte_read: assert property (p_byte_read) else $error("byte read not low byte");

	property p_byte_wr;
		@(posedge ref_clk) disable iff (srst)
		(byte_wr && !wd_reset_q) |=> soft_system_reset ##1 (ctl_q == pwit_pkg::CTL_RST);
	endproperty
	a_byte_wr: assert property (p_byte_wr) else $error("byte write did not reset");

	property p_wd_expire;
		@(posedge ref_clk) disable iff (srst)
		(!ctl_q.tmsel && expire && !wd_reset_q) |=> soft_system_reset;
	endproperty
	a_wd_expire: assert property (p_wd_expire) else $error("watchdog expiry did not reset");

	property p_interval;
		@(posedge ref_clk) disable iff (srst)
		(ctl_q.tmsel && expire && !pw_bad && !byte_wr && !soft_rst) |=> !soft_system_reset && timeout_flag_q;
	endproperty
	a_interval: assert property (p_interval) else $error("interval expiry misbehaved");

	property p_irq;
		@(posedge ref_clk) disable iff (srst)
		interval_irq |-> $past(ctl_q.tmsel && timeout_flag_q && interval_irq_enable_q && global_irq_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without cause");

	property p_hold;
		@(posedge ref_clk) disable iff (srst)
		(ctl_q.hold && !ctl_wr && !soft_rst) |=> $stable(timeout_counter_q);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while held");

	property p_clear;
		@(posedge ref_clk) disable iff (srst)
		(ctl_wr && pwdata[pwit_pkg::CLR_BIT]) |=> (timeout_counter_q == 32'h0);
	endproperty
	a_clear: assert property (p_clear) else $error("counter clear ignored");

	property p_failsafe;
		@(posedge ref_clk) disable iff (srst)
		(!ctl_q.tmsel && ctl_q.ssel == pwit_pkg::SRC_SUB_MAIN && sub_main_clock_fail) |->
			(tick == (vlo_tick && !ctl_q.hold));
	endproperty
	a_failsafe: assert property (p_failsafe) else $error("fail-safe clock not used");

	property p_failsafe_aux;
		@(posedge ref_clk) disable iff (srst)
		(!ctl_q.tmsel && ctl_q.ssel == pwit_pkg::SRC_ACLK && aclk_fail) |-> (tick == (vlo_tick && !ctl_q.hold));
	endproperty
	a_failsafe_aux: assert property (p_failsafe_aux) else $error("aux fail-safe clock not used");

	property p_no_sub;
		@(posedge ref_clk) disable iff (srst)
		(ctl_q.tmsel && ctl_q.ssel == pwit_pkg::SRC_SUB_MAIN) |-> (tick == (sub_main_clock_tick && !ctl_q.hold));
	endproperty
	a_no_sub: assert property (p_no_sub) else $error("interval mode substituted a clock");

	property p_keep_wd;
		@(posedge ref_clk) disable iff (srst)
		!ctl_q.tmsel |=> $onehot(clk_keep);
	endproperty
	a_keep_wd: assert property (p_keep_wd) else $error("watchdog clock not kept running");

	property p_keep_int;
		@(posedge ref_clk) disable iff (srst)
		ctl_q.tmsel |=> (clk_keep == 4'h0);
	endproperty
	a_keep_int: assert property (p_keep_int) else $error("interval mode kept a clock");

	property p_ie_kept;
		@(posedge ref_clk) disable iff (srst)
		(!(wr && hit_ie && pstrb[0]) && !soft_rst) |=> $stable(interval_irq_enable_q);
	endproperty
	a_ie_kept: assert property (p_ie_kept) else $error("interval enable changed by hardware");

	property p_other_reset;
		@(posedge ref_clk) disable iff (srst)
		(other_soft_reset && !wd_reset_q) |=> !timeout_flag_q && (ctl_q == pwit_pkg::CTL_RST);
	endproperty
	a_other_reset: assert property (p_other_reset) else $error("other reset left flag or control");

	property p_ack;
		@(posedge ref_clk) disable iff (srst)
		(irq_ack && interval_irq && !(ctl_q.tmsel && expire) && !wd_reset_q) |=> !timeout_flag_q;
	endproperty
	a_ack: assert property (p_ack) else $error("serviced flag not cleared");

	property p_sw_clear;
		@(posedge ref_clk) disable iff (srst)
		(wr && hit_flag && pstrb[0] && !pwdata[pwit_pkg::FLAG_BIT] && !wd_reset_q && !(ctl_q.tmsel && expire))
			|=> !timeout_flag_q;
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("software clear of flag ignored");

	property p_ctl_write;
		@(posedge ref_clk) disable iff (srst)
		(ctl_wr && !soft_rst) |=> (ctl_q.tmsel == $past(pwdata[pwit_pkg::TMSEL_BIT])) &&
			(ctl_q.hold == $past(pwdata[pwit_pkg::HOLD_BIT])) && (ctl_q.isel == $past(pwdata[pwit_pkg::IS_LSB +: 3]));
	endproperty
	a_ctl_write: assert property (p_ctl_write) else $error("control write not stored");

	property p_count_up;
		@(posedge ref_clk) disable iff (srst)
		(tick && !soft_rst && !(ctl_wr && pwdata[pwit_pkg::CLR_BIT])) |=>
			(timeout_counter_q == $past(timeout_counter_q) + 32'h1);
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter did not count up");

	property p_pw_keep;
		@(posedge ref_clk) disable iff (srst)
		(pw_bad && !soft_rst) |=> $stable(ctl_q);
	endproperty
	a_pw_keep: assert property (p_pw_keep) else $error("bad password changed control");

	property p_tap;
		@(posedge ref_clk) disable iff (srst)
		expire |-> (timeout_counter_q[5:0] == 6'h3F);
	endproperty
	a_tap: assert property (p_tap) else $error("expiry below the shortest tap");

endmodule

// [pwit_pkg.sv]
// pwit_pkg: constants, control field layout and types for the password watchdog / interval timer
// assumes a 32-bit apb slave port with byte strobes and a single 25 MHz ref_clk
package pwit_pkg;

	// apb byte addresses
	localparam logic [11:0] ADDR_FLAG = 12'h000;
	localparam logic [11:0] ADDR_IE   = 12'h004;
	localparam logic [11:0] ADDR_CTL  = 12'h00C;
	localparam logic [11:0] ADDR_BYTE = 12'h010;

	// password byte, written and read
	localparam logic [7:0] PW_WRITE = 8'h5A;
	localparam logic [7:0] PW_READ  = 8'h69;

	// control low byte fields
	localparam int HOLD_BIT  = 7;
	localparam int SSEL_LSB  = 5;
	localparam int TMSEL_BIT = 4;
	localparam int CLR_BIT   = 3;
	localparam int IS_LSB    = 0;

	// flag and enable sit at bit 0 of their registers
	localparam int FLAG_BIT = 0;
	localparam int IE_BIT   = 0;

	// clock source codes
	localparam logic [1:0] SRC_SUB_MAIN = 2'h0;
	localparam logic [1:0] SRC_ACLK     = 2'h1;
	localparam logic [1:0] SRC_VLO      = 2'h2;
	localparam logic [1:0] SRC_XCLK     = 2'h3;

	// expiry taps as log2 of the divider, codes 000 to 111
	localparam int TAP_W [8] = '{31, 27, 23, 19, 15, 13, 9, 6};

	// initial timeout, about 32 ms with a 1 MHz sub-main clock at /32k
	localparam int INIT_TIMEOUT_MS = 32;

	typedef struct packed {
		logic       hold;
		logic [1:0] ssel;
		logic       tmsel;
		logic [2:0] isel;
	} pwit_ctl_t;

	// reset value of the low byte is 04h: watchdog, sub-main clock, /32k
	localparam pwit_ctl_t CTL_RST = '{hold: 1'b0, ssel: 2'h0, tmsel: 1'b0, isel: 3'h4};

	typedef struct packed {
		logic sub_main_clock;
		logic aclk;
		logic vlo;
		logic xclk;
	} pwit_src_t;

endpackage

// [pwit_src_model.sv]
// pwit_src_model: partner that supplies one-cycle tick enables for the four counter clock sources
// assumes ref_clk is faster than every source; slow paces each running source to one tick in four cycles
`timescale 1ns/1ps
module pwit_src_model (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	// which sources run, and their pace
	input  wire pwit_pkg::pwit_src_t  run,
	input  wire logic                 slow,
	// tick enables toward the timer
	output pwit_pkg::pwit_src_t       ticks
);
	logic [1:0] phase_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// a stopped or failed source gives no ticks at all, as a dead oscillator would
	assign ticks = (slow && phase_q != 2'h0) ? 4'h0 : run;
endmodule

// [password_watchdog_interval_timer_test.sv]
// password_watchdog_interval_timer_test: self-checking bench for pwit_timer
// assumes pwit_src_model drives the source ticks and apb answers after one wait state
`timescale 1ns/1ps
module password_watchdog_interval_timer_test;
	logic                ref_clk    = 1'b0;
	logic                srst       = 1'b1;
	logic [11:0]         paddr      = 12'h000;
	logic                psel       = 1'b0;
	logic                penable    = 1'b0;
	logic                pwrite     = 1'b0;
	logic [31:0]         pwdata     = 32'h00000000;
	logic [3:0]          pstrb      = 4'hF;
	logic                slow       = 1'b0;
	logic                sub_main_clock_fail = 1'b0;
	logic                aclk_fail           = 1'b0;
	logic                other_soft_reset    = 1'b0;
	logic                global_irq_enable   = 1'b1;
	logic                irq_ack    = 1'b0;
	pwit_pkg::pwit_src_t run        = 4'hF;
	pwit_pkg::pwit_src_t ticks, clk_keep;
	logic [31:0]         prdata;
	logic                pready, pslverr, soft_system_reset, interval_irq;
	logic [32:0]         exp_q[$];
	logic [7:0]          lfsr       = 8'h3E;
	int                  fails = 0, n_tests = 0, cycles = 0, n_resets = 0, r0;

	pwit_src_model src (.ref_clk(ref_clk), .srst(srst), .run(run), .slow(slow), .ticks(ticks));
	pwit_timer uut (.ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sub_main_clock_tick(ticks.sub_main_clock), .aclk_tick(ticks.aclk), .vlo_tick(ticks.vlo),
		.xclk_tick(ticks.xclk), .sub_main_clock_fail(sub_main_clock_fail), .aclk_fail(aclk_fail),
		.other_soft_reset(other_soft_reset), .global_irq_enable(global_irq_enable),
		.irq_ack(irq_ack), .soft_system_reset(soft_system_reset), .interval_irq(interval_irq),
		.clk_keep(clk_keep));

	always #20 ref_clk = ~ref_clk;

	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction

	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (fails == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fails++;
			stop_test();
		end
	end

	// sampled mid-cycle so the registered outputs have settled
	always @(negedge ref_clk) begin
		if (soft_system_reset === 1'b1) n_resets++;
		if (pready === 1'b1 && psel && !pwrite) check("apb read", {pslverr, prdata}, exp_q.pop_front());
	end

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk);
		penable <= 1'b1;
		while (pready !== 1'b1) @(negedge ref_clk);
		@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(a, 1'b0, 32'h0, 4'hF);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 4'hF);
	endtask

	task automatic ctl(input logic [7:0] low);
		wr(pwit_pkg::ADDR_CTL, {16'h0, pwit_pkg::PW_WRITE, low});
	endtask

	// k 0 watches the soft reset, 1 the interval request; it must rise after lo and before hi cycles
	// lo equal to hi asks that it stays low for all hi cycles
	task automatic ev(input string what, input int k, input int lo, input int hi);
		int n;
		for (n = 0; n < hi && (k == 0 ? soft_system_reset : interval_irq) !== 1'b1; n++) @(negedge ref_clk);
		check(what, 33'(lo == hi ? n == hi : n >= lo && n < hi), 33'h1);
	endtask

	initial begin
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		// keep-alive only shows one edge after release
		repeat (2) @(negedge ref_clk);
		check("keep", 33'(clk_keep), 33'h8);
		rd(pwit_pkg::ADDR_CTL, 33'h6904);
		ev("boot timeout", 0, 32740, 32790);
		repeat (2) @(negedge ref_clk);
		rd(pwit_pkg::ADDR_FLAG, 33'h1);
		rd(12'h008, 33'h100000000);
		wr(pwit_pkg::ADDR_IE, 32'h1);
		wr(pwit_pkg::ADDR_FLAG, 32'h0);
		ctl(8'h1F);
		rd(pwit_pkg::ADDR_CTL, 33'h6917);
		rd(pwit_pkg::ADDR_BYTE, 33'h1717);
		check("keep", 33'(clk_keep), 33'h0);
		r0 = n_resets;
		ev("interval", 1, 40, 72);
		@(posedge ref_clk);
		irq_ack <= 1'b1;
		@(posedge ref_clk);
		irq_ack <= 1'b0;
		repeat (2) @(negedge ref_clk);
		check("ack", 33'(interval_irq), 33'h0);
		ev("recurring", 1, 50, 72);
		check("resets", 33'(n_resets), 33'(r0));
		rd(pwit_pkg::ADDR_IE, 33'h1);
		global_irq_enable <= 1'b0;
		wr(pwit_pkg::ADDR_FLAG, 32'h0);
		rd(pwit_pkg::ADDR_FLAG, 33'h0);
		ev("enable low", 1, 100, 100);
		rd(pwit_pkg::ADDR_FLAG, 33'h1);
		global_irq_enable <= 1'b1;
		ev("enable high", 1, 0, 4);
		ctl(8'h1F);
		wr(pwit_pkg::ADDR_FLAG, 32'h0);
		repeat (30) @(posedge ref_clk);
		ctl(8'h97);
		ev("held", 1, 200, 200);
		ctl(8'h17);
		ev("resume", 1, 5, 40);
		wr(pwit_pkg::ADDR_FLAG, 32'h0);
		// hold before each source change, else a stale count could expire early
		for (int s = 0; s < 4; s++) begin
			ctl(8'h97);
			run <= 4'h8 >> s;
			slow <= rnd() > 8'h7F;
			ctl({1'b0, s[1:0], 5'h1F});
			ev("source", 1, slow ? 200 : 50, slow ? 288 : 72);
			wr(pwit_pkg::ADDR_FLAG, 32'h0);
		end
		ctl(8'h97);
		run <= 4'h2;
		slow <= 1'b0;
		sub_main_clock_fail <= 1'b1;
		ctl(8'h1F);
		ev("no substitution", 1, 150, 150);
		ctl(8'h0F);
		ev("failsafe", 0, 50, 72);
		@(posedge ref_clk);
		aclk_fail <= 1'b1;
		ctl(8'h2F);
		ev("aux failsafe", 0, 50, 72);
		@(posedge ref_clk);
		run <= 4'hF;
		sub_main_clock_fail <= 1'b0;
		aclk_fail <= 1'b0;
		repeat (2) @(negedge ref_clk);
		rd(pwit_pkg::ADDR_CTL, 33'h6904);
		@(posedge ref_clk);
		other_soft_reset <= 1'b1;
		@(posedge ref_clk);
		other_soft_reset <= 1'b0;
		rd(pwit_pkg::ADDR_FLAG, 33'h0);
		ctl(8'h1F);
		r0 = n_resets;
		wr(pwit_pkg::ADDR_CTL, {16'h0, (rnd() == 8'h5A) ? 8'h00 : lfsr, 8'h1F});
		repeat (4) @(negedge ref_clk);
		check("password", 33'(n_resets), 33'(r0 + 1));
		rd(pwit_pkg::ADDR_FLAG, 33'h1);
		rd(pwit_pkg::ADDR_CTL, 33'h6904);
		for (int i = 0; i < 3; i++) begin
			ctl(8'h1F);
			r0 = n_resets;
			apb(i == 2 ? pwit_pkg::ADDR_BYTE : pwit_pkg::ADDR_CTL, 1'b1, 32'h5A1F, i == 2 ? 4'hF : 4'h1 << i);
			repeat (4) @(negedge ref_clk);
			check("byte write", 33'(n_resets), 33'(r0 + 1));
		end
		stop_test();
	end
endmodule
